// >>> mmf_checker.sv
// Purpose: Port assertions of the framer
// Assumes: Bound to mmf_framer
// Notes:   Frame byte index is counted from taken bytes
`timescale 1ns/1ps
module mmf_checker (
	input logic        sys_clk,
	input logic        reset,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        strm_valid,
	input logic        strm_ready,
	input logic [7:0]  strm_data,
	input logic        strm_last
);
	logic [7:0] idx_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Position of the offered byte within its frame
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			idx_q <= 8'h00;
		else if (strm_valid && strm_ready)
			idx_q <= strm_last ? 8'h00 : idx_q + 8'h01;
	end
	AST_APB_WAIT: assert property (
		psel && penable && !pready |=> pready) else $error("no answer");
	AST_APB_ONE: assert property (
		pready |=> !pready) else $error("long pready");
	AST_ERR_RDY: assert property (
		pslverr |-> pready) else $error("stray error");
	AST_UNMAP: assert property (
		pready && paddr > 8'h14 |-> pslverr) else $error("unmapped ok");
	AST_TEXT_RD: assert property (
		pready && !pwrite && paddr == 8'h10 |-> prdata == 32'h0)
		else $error("text read");
	AST_HOLD: assert property (
		strm_valid && !strm_ready |=> strm_valid && $stable(strm_data)
		&& $stable(strm_last)) else $error("byte dropped");
	AST_HDR0: assert property (
		strm_valid && idx_q == 8'h00 |-> strm_data == 8'h00
		|| strm_data == 8'hff) else $error("bad first byte");
	AST_HDR1: assert property (
		strm_valid && idx_q == 8'h01 |-> strm_data == 8'h00
		|| strm_data == 8'hfe) else $error("bad second byte");
	AST_HDR2: assert property (
		strm_valid && idx_q == 8'h02 |-> strm_data <= 8'h01)
		else $error("bad third byte");
	AST_RST_IDLE: assert property (
		$fell(reset) |-> !strm_valid && !pready) else $error("busy");
	cover property (strm_valid && strm_ready && strm_last);
	cover property (strm_valid && !strm_ready);
	cover property (pslverr);
endmodule // mmf_checker

// >>> mmf_defs.vh
// Purpose: Constants of the metadata message framer
// Assumes: Included by the framer design file and the bench
// Notes:   Offsets are APB byte addresses, counts are bytes
`ifndef MMF_DEFS_VH
`define MMF_DEFS_VH

// Register byte offsets
`define MMF_CTRL_OFS       8'h00
`define MMF_INTERVAL_OFS   8'h04
`define MMF_INFO_LENS_OFS  8'h08
`define MMF_USER_LEN_OFS   8'h0c
`define MMF_TEXT_WR_OFS    8'h10
`define MMF_STATUS_OFS     8'h14

// Reset values
`define MMF_CTRL_RST       3'h0
`define MMF_INTERVAL_RST   32'h00000000
`define MMF_LENS_RST       18'h00000
`define MMF_USER_LEN_RST   7'h00

// Codec selection in CTRL[2:1]
`define MMF_CODEC_MPEG     2'h0
`define MMF_CODEC_MJPEG    2'h1
`define MMF_CODEC_H264     2'h2

// Message kinds, in emission order
`define MMF_MSG_INFO       2'h0
`define MMF_MSG_STATUS     2'h1
`define MMF_MSG_USER       2'h2

// Container bytes
`define MMF_USER_START     8'hb2
`define MMF_START_PREFIX   8'h01
`define MMF_CMT_MARK0      8'hff
`define MMF_CMT_MARK1      8'hfe
`define MMF_SEI_NAL        8'h06
`define MMF_SEI_UNREG      8'h05
`define MMF_RBSP_TRAIL     8'h80
`define MMF_FIELD_END      8'h80
`define MMF_ID_INFO        8'h00
`define MMF_ID_STATUS      8'h01

// Lengths
`define MMF_HDR_LEN_SHORT  8'h04
`define MMF_HDR_LEN_H264   8'h06
`define MMF_INFO_FIXED     8'h08
`define MMF_STATUS_LEN     8'h09
`define MMF_PAYLOAD_OFS    8'h05
`define MMF_CMT_SIZE_ADD   16'h0002
`define MMF_TEXT_DEPTH     128
`define MMF_FIFO_DEPTH     8

`endif

// >>> mmf_framer.v
// Purpose: Frames product, status and user metadata into a byte stream
// Assumes: One instance per encoder, APB slave, bytes drained by the mux
// Notes:   Summary of operation is listed below
`timescale 1ns/1ps
`include "mmf_defs.vh"

// Plain FIFO with valid and ready on both sides
module mmf_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             sys_clk,
	input  wire             reset,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      count_q;
	wire            push;
	wire            pop;

	// Handshake terms
	assign in_ready  = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage, no reset needed
	always @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	// Pointers and fill level
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // mmf_fifo

module mmf_framer #(
	// Signature characters; value is arbitrary
	parameter [31:0] SIGNATURE = 32'h4d444652
) (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        video_loss,
	input  wire        video_bw,
	input  wire        motion_detect_alarm,
	input  wire        tamper_alarm,
	input  wire        quality_alarm,
	input  wire        temperature_alarm,
	input  wire        audio_present,
	input  wire [6:0]  contact_input_1,
	input  wire        contact_input_8,
	output reg         strm_valid,
	input  wire        strm_ready,
	output reg  [7:0]  strm_data,
	output reg         strm_last
);
	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	reg  [7:0]  text_mem [0:`MMF_TEXT_DEPTH-1];
	reg  [2:0]  ctrl_q;
	reg  [31:0] interval_q;
	reg  [17:0] lens_q;
	reg  [6:0]  user_len_q;
	reg  [31:0] tick_q;
	reg         pending_q;
	reg         state_q;
	reg  [1:0]  msg_q;
	reg  [1:0]  codec_q;
	reg  [7:0]  pos_q;
	reg  [12:0] snap_q;
	reg  [6:0]  cl_q;
	reg  [7:0]  body_len;
	reg  [7:0]  hdr_len;
	reg  [7:0]  frame_len;
	reg  [7:0]  cur_byte;
	reg  [7:0]  bidx;
	reg  [7:0]  tj;
	reg  [15:0] cmt_size;
	wire        apb_hit;
	wire        do_wr;
	wire        valid_addr;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [8:0]  fifo_out_data;
	wire        gen_push;
	wire        frame_end;
	wire        fifo_pop;
	wire [5:0]  name_len;
	wire [5:0]  serial_len;
	wire [5:0]  version_len;
	wire [7:0]  video_status_byte;
	wire [7:0]  general_status_byte;
	wire [7:0]  contact_status_low_byte;
	wire [7:0]  contact_status_high_byte;

	// Signature byte by position
	function [7:0] sig_byte;
		input [1:0] i;
		begin
			sig_byte = SIGNATURE[31 - 8*i -: 8];
		end
	endfunction

	assign name_len    = lens_q[5:0];
	assign serial_len  = lens_q[11:6];
	assign version_len = lens_q[17:12];

	// APB decode; one wait state per transfer
	assign apb_hit    = psel & penable & pready;
	assign do_wr      = apb_hit & pwrite & valid_addr;
	assign valid_addr = (paddr == `MMF_CTRL_OFS) |
		(paddr == `MMF_INTERVAL_OFS) | (paddr == `MMF_INFO_LENS_OFS) |
		(paddr == `MMF_USER_LEN_OFS) | (paddr == `MMF_TEXT_WR_OFS) |
		(paddr == `MMF_STATUS_OFS);

	// Bus answer, registers and read data
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
			ctrl_q     <= `MMF_CTRL_RST;
			interval_q <= `MMF_INTERVAL_RST;
			lens_q     <= `MMF_LENS_RST;
			user_len_q <= `MMF_USER_LEN_RST;
		end
		else
		begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~valid_addr;
			prdata  <= 32'h00000000;
			if (psel & penable & ~pready & ~pwrite)
			begin
				case (paddr)
				`MMF_CTRL_OFS:      prdata <= {29'h0, ctrl_q};
				`MMF_INTERVAL_OFS:  prdata <= interval_q;
				`MMF_INFO_LENS_OFS: prdata <= {14'h0, lens_q};
				`MMF_USER_LEN_OFS:  prdata <= {25'h0, user_len_q};
				`MMF_STATUS_OFS:
					prdata <= {16'h0, 3'h0, snap_q[4:0], codec_q,
						msg_q, 2'h0, pending_q, state_q};
				default:            prdata <= 32'h00000000;
				endcase
			end
			if (do_wr)
			begin
				case (paddr)
				`MMF_CTRL_OFS:      ctrl_q <= pwdata[2:0];
				`MMF_INTERVAL_OFS:  interval_q <= pwdata;
				`MMF_INFO_LENS_OFS: lens_q <= pwdata[17:0];
				`MMF_USER_LEN_OFS:  user_len_q <= pwdata[6:0];
				default:            ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	// Text memory: info strings low half, user text high half
	always @(posedge sys_clk)
	begin
		if (do_wr && paddr == `MMF_TEXT_WR_OFS)
			text_mem[pwdata[6:0]] <= pwdata[15:8];
	end

	// Status bytes from the latched snapshot
	assign video_status_byte        = {3'h0, snap_q[4:0]};
	assign general_status_byte      = {2'h1, snap_q[6], 4'h0,
		snap_q[5]};
	assign contact_status_low_byte  = {1'b0, cl_q};
	assign contact_status_high_byte = {2'h1, 5'h00, snap_q[12]};

	// Interval timer raises a burst request
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			tick_q    <= 32'h00000000;
			pending_q <= 1'b0;
		end
		else if (~ctrl_q[0] || interval_q == 32'h00000000)
		begin
			tick_q    <= 32'h00000000;
			pending_q <= 1'b0;
		end
		else
		begin
			if (tick_q >= interval_q - 32'h00000001)
				tick_q <= 32'h00000000;
			else
				tick_q <= tick_q + 32'h00000001;
			// Expiry wins over the burst start clearing it
			if (tick_q >= interval_q - 32'h00000001)
				pending_q <= 1'b1;
			else if (state_q == ST_IDLE)
				pending_q <= 1'b0;
		end
	end

	// Payload length of the current message
	always @*
	begin
		case (msg_q)
		`MMF_MSG_INFO:
			body_len = `MMF_INFO_FIXED + {2'h0, name_len} +
				{2'h0, serial_len} + {2'h0, version_len};
		`MMF_MSG_STATUS: body_len = `MMF_STATUS_LEN;
		default:         body_len = {1'b0, user_len_q};
		endcase
		hdr_len   = (codec_q == `MMF_CODEC_H264) ?
			`MMF_HDR_LEN_H264 : `MMF_HDR_LEN_SHORT;
		frame_len = hdr_len + body_len +
			((codec_q == `MMF_CODEC_H264) ? 8'h01 : 8'h00);
		cmt_size  = {8'h00, body_len} + `MMF_CMT_SIZE_ADD;
	end

	// Byte at the current frame position
	always @*
	begin
		bidx     = pos_q - hdr_len;
		tj       = bidx - `MMF_PAYLOAD_OFS;
		cur_byte = 8'h00;
		if (pos_q < hdr_len)
		begin
			case (codec_q)
			`MMF_CODEC_MJPEG:
				case (pos_q[1:0])
				2'h0:    cur_byte = `MMF_CMT_MARK0;
				2'h1:    cur_byte = `MMF_CMT_MARK1;
				2'h2:    cur_byte = cmt_size[15:8];
				default: cur_byte = cmt_size[7:0];
				endcase
			`MMF_CODEC_H264:
				case (pos_q[2:0])
				3'h2:    cur_byte = `MMF_START_PREFIX;
				3'h3:    cur_byte = `MMF_SEI_NAL;
				3'h4:    cur_byte = `MMF_SEI_UNREG;
				3'h5:    cur_byte = body_len;
				default: cur_byte = 8'h00;
				endcase
			default:
				case (pos_q[1:0])
				2'h2:    cur_byte = `MMF_START_PREFIX;
				2'h3:    cur_byte = `MMF_USER_START;
				default: cur_byte = 8'h00;
				endcase
			endcase
		end
		else if (bidx >= body_len)
			cur_byte = `MMF_RBSP_TRAIL;
		else if (msg_q == `MMF_MSG_USER)
			cur_byte = text_mem[{1'b1, bidx[5:0]}];
		else if (bidx < 8'h04)
			cur_byte = sig_byte(bidx[1:0]);
		else if (bidx == 8'h04)
			cur_byte = (msg_q == `MMF_MSG_INFO) ?
				`MMF_ID_INFO : `MMF_ID_STATUS;
		else if (msg_q == `MMF_MSG_STATUS)
			case (tj[1:0])
			2'h0:    cur_byte = video_status_byte;
			2'h1:    cur_byte = general_status_byte;
			2'h2:    cur_byte = contact_status_low_byte;
			default: cur_byte = contact_status_high_byte;
			endcase
		else if (tj < {2'h0, name_len})
			cur_byte = text_mem[{1'b0, tj[5:0]}];
		else if (tj == {2'h0, name_len})
			cur_byte = `MMF_FIELD_END;
		else if (tj < {2'h0, name_len} + {2'h0, serial_len} + 8'h01)
			cur_byte = text_mem[{1'b0, tj[5:0] - 6'h01}];
		else if (tj == {2'h0, name_len} + {2'h0, serial_len} + 8'h01)
			cur_byte = `MMF_FIELD_END;
		else if (tj < `MMF_INFO_FIXED - `MMF_PAYLOAD_OFS - 8'h01 +
			{2'h0, name_len} + {2'h0, serial_len} + {2'h0, version_len})
			cur_byte = text_mem[{1'b0, tj[5:0] - 6'h02}];
		else
			cur_byte = `MMF_FIELD_END;
	end

	assign gen_push  = (state_q == ST_SEND) & fifo_in_ready;
	assign frame_end = (pos_q == frame_len - 8'h01);

	// Burst sequencer: info, status, then user text
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= ST_IDLE;
			msg_q   <= `MMF_MSG_INFO;
			codec_q <= `MMF_CODEC_MPEG;
			pos_q   <= 8'h00;
			snap_q  <= 13'h0000;
			cl_q    <= 7'h00;
		end
		else
		begin
			case (state_q)
			ST_IDLE:
				if (pending_q & ctrl_q[0])
				begin
					state_q <= ST_SEND;
					msg_q   <= `MMF_MSG_INFO;
					codec_q <= ctrl_q[2:1];
					pos_q   <= 8'h00;
					snap_q  <= {contact_input_8, 1'b0, 2'h0, 2'h0,
						audio_present, temperature_alarm,
						quality_alarm, tamper_alarm,
						motion_detect_alarm, video_bw, video_loss};
					cl_q    <= contact_input_1;
				end
			ST_SEND:
				if (gen_push)
				begin
					if (!frame_end)
						pos_q <= pos_q + 8'h01;
					else
					begin
						pos_q <= 8'h00;
						if (msg_q == `MMF_MSG_INFO)
							msg_q <= `MMF_MSG_STATUS;
						else if (msg_q == `MMF_MSG_STATUS &&
							user_len_q != 7'h00)
							msg_q <= `MMF_MSG_USER;
						else
							state_q <= ST_IDLE;
					end
				end
			default:
				state_q <= ST_IDLE;
			endcase
		end
	end

	// Eight-word buffer toward the stream mux
	mmf_fifo #(
		.WIDTH (9),
		.DEPTH (`MMF_FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_valid  (gen_push),
		.in_ready  (fifo_in_ready),
		.in_data   ({frame_end, cur_byte}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	assign fifo_pop = fifo_out_valid & (~strm_valid | strm_ready);

	// Registered stream output stage
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			strm_valid <= 1'b0;
			strm_data  <= 8'h00;
			strm_last  <= 1'b0;
		end
		else if (~strm_valid | strm_ready)
		begin
			strm_valid <= fifo_out_valid;
			strm_data  <= fifo_out_data[7:0];
			strm_last  <= fifo_out_data[8];
		end
	end
endmodule // mmf_framer

// >>> mmf_framer_tb_top.sv
// Purpose: Self-checking bench of the framer
// Assumes: Sink model on the stream side
// Notes:   Frames built from fixed text and status patterns
`timescale 1ns/1ps
`include "mmf_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module mmf_framer_tb_top;
	localparam [31:0] SIG = 32'h41424344; // Arbitrary signature value
	localparam int    N   = 400;
	logic        sys_clk = 0, reset = 1, psel = 0, penable = 0;
	logic        pwrite = 0, slow = 0, temp = 0, aud = 0, cc8 = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, strm_valid, strm_ready, strm_last, er;
	logic [7:0]  strm_data, xp[$], pl[$];
	logic [4:0]  vid = 0;
	logic [6:0]  cc = 0;
	logic        el[$];
	int          errors = 0, compares = 0;
	logic [7:0]  sg[$] = {SIG[31:24], SIG[23:16], SIG[15:8], SIG[7:0]};
	always #50 sys_clk = ~sys_clk;
	mmf_framer #(.SIGNATURE(SIG)) mmf_framer_i (.sys_clk(sys_clk),
		.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .video_loss(vid[0]), .video_bw(vid[1]),
		.motion_detect_alarm(vid[2]), .tamper_alarm(vid[3]),
		.quality_alarm(vid[4]), .temperature_alarm(temp),
		.audio_present(aud), .contact_input_1(cc), .contact_input_8(cc8),
		.strm_valid(strm_valid), .strm_ready(strm_ready),
		.strm_data(strm_data), .strm_last(strm_last));
	mmf_sink mmf_sink_i (.sys_clk(sys_clk), .reset(reset), .slow(slow),
		.strm_valid(strm_valid), .strm_data(strm_data),
		.strm_last(strm_last), .strm_ready(strm_ready));
	task report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One APB transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do begin @(posedge sys_clk); n++; end while (pready !== 1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1)
		begin
			errors++;
			report_and_stop;
		end
	endtask
	// Wraps pl in the container of codec c
	task frame(input int c);
		int n;
		n = pl.size();
		if (c == 1)
			xp = {xp, 8'hff, 8'hfe, 8'((n + 2) >> 8), 8'(n + 2)};
		else
			xp = {xp, 8'h00, 8'h00, 8'h01, c == 2 ? 8'h06 : 8'hb2};
		if (c == 2)
			xp = {xp, 8'h05, 8'(n)};
		xp = {xp, pl};
		if (c == 2)
			xp.push_back(8'h80);
		for (int i = el.size(); i < xp.size(); i++)
			el.push_back(i == xp.size() - 1);
	endtask
	task regs;
		apb(0, `MMF_CTRL_OFS, 0);
		`CHK("ctrl", 32'h0, rd)
		apb(0, `MMF_INTERVAL_OFS, 0);
		`CHK("interval", 32'h0, rd)
		apb(0, 8'h20, 0);
		`CHK("unmapped", 1'b1, er)
		apb(0, `MMF_TEXT_WR_OFS, 0);
		`CHK("text read", 32'h0, rd)
		apb(1, `MMF_CTRL_OFS, 32'h1);
		repeat (N + 100) @(posedge sys_clk);
		`CHK("no insert", 0, mmf_sink_i.q.size())
		apb(1, `MMF_CTRL_OFS, 0);
	endtask
	task automatic load;
		logic [7:0] t[6] = '{"A", "B", "7", "V", "h", "i"};
		apb(1, `MMF_INFO_LENS_OFS, 32'h1042);
		apb(0, `MMF_INFO_LENS_OFS, 0);
		`CHK("lens", 32'h1042, rd)
		apb(1, `MMF_USER_LEN_OFS, 32'h2);
		foreach (t[i])
			apb(1, `MMF_TEXT_WR_OFS, {16'h0, t[i], 8'(i < 4 ? i : i + 60)});
		apb(1, `MMF_INTERVAL_OFS, N);
	endtask
	// One burst in codec c, status pattern p, sink speed s
	task run_codec(input logic [1:0] c, input logic p, input logic s);
		int n;
		vid <= p ? 5'h0a : 5'h15;
		temp <= !p;
		aud <= !p;
		cc <= p ? 7'h2a : 7'h55;
		cc8 <= !p;
		slow <= s;
		xp.delete();
		el.delete();
		pl = {sg, 8'h00, "A", "B", 8'h80, "7", 8'h80, "V", 8'h80};
		frame(c);
		pl = {sg, 8'h01, p ? 8'h0a : 8'h15, p ? 8'h40 : 8'h61,
			p ? 8'h2a : 8'h55, p ? 8'h40 : 8'h41};
		frame(c);
		pl = {"h", "i"};
		frame(c);
		mmf_sink_i.q.delete();
		mmf_sink_i.lq.delete();
		mmf_sink_i.fr = 0;
		apb(1, `MMF_CTRL_OFS, {29'h0, c, 1'b1});
		n = 0;
		while (strm_valid !== 1 && n < N + 20)
		begin
			@(posedge sys_clk);
			n++;
		end
		`CHK("start", 1'b1, n <= N + 10)
		// A burst that never starts ends the run
		if (strm_valid !== 1)
			report_and_stop;
		n = 0;
		while (mmf_sink_i.fr < 3 && n < 4000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (mmf_sink_i.fr < 3)
		begin
			errors++;
			report_and_stop;
		end
		apb(1, `MMF_CTRL_OFS, 0);
		repeat (300) @(posedge sys_clk);
		// Idle, last message user text, latched codec and alarms
		apb(0, `MMF_STATUS_OFS, 0);
		`CHK("status", {19'h0, vid, c, 2'h2, 4'h0}, rd)
		`CHK("count", xp.size(), mmf_sink_i.q.size())
		foreach (xp[i])
		begin
			if (i < mmf_sink_i.q.size())
			begin
				`CHK("byte", xp[i], mmf_sink_i.q[i])
				`CHK("last", el[i], mmf_sink_i.lq[i])
			end
		end
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset <= 0;
		regs;
		load;
		run_codec(`MMF_CODEC_MPEG, 0, 0);
		run_codec(`MMF_CODEC_MJPEG, 1, 1);
		run_codec(`MMF_CODEC_H264, 0, 1);
		run_codec(`MMF_CODEC_H264, 1, 0);
		report_and_stop;
	end
endmodule // mmf_framer_tb_top
bind mmf_framer mmf_checker mmf_checker_i (.sys_clk(sys_clk),
	.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.strm_valid(strm_valid), .strm_ready(strm_ready),
	.strm_data(strm_data), .strm_last(strm_last));

// >>> mmf_sink.sv
// Purpose: Stream sink standing for the output mux
// Assumes: One byte taken per valid and ready edge
// Notes:   Slow mode is ready one cycle in four
`timescale 1ns/1ps
module mmf_sink (
	input  logic       sys_clk,
	input  logic       reset,
	input  logic       slow,
	input  logic       strm_valid,
	input  logic [7:0] strm_data,
	input  logic       strm_last,
	output logic       strm_ready
);
	logic [7:0] q[$];
	logic       lq[$];
	logic [1:0] ph_q;
	int         fr;
	// Collects bytes and counts frame ends
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			ph_q <= 2'h0;
			strm_ready <= 1'b0;
		end
		else
		begin
			if (strm_valid && strm_ready)
			begin
				q.push_back(strm_data);
				lq.push_back(strm_last);
				fr = fr + int'(strm_last);
			end
			ph_q <= ph_q + 2'h1;
			strm_ready <= !slow || ph_q == 2'h2;
		end
	end
endmodule // mmf_sink
